// file: cbx_pkg.sv
// Constants, types and helpers for the compare, barrier and xor execute block
package cbx_pkg;

  // ************************************************************
  // Register map (byte addresses on the AXI4-Lite slave)
  // ************************************************************
  localparam logic [7:0] OFS_INSTR    = 8'h00;  // Halfword issue port
  localparam logic [7:0] OFS_CTRL     = 8'h04;  // Conditional-block control
  localparam logic [7:0] OFS_FLAGS    = 8'h08;  // Flag status word
  localparam logic [7:0] OFS_STATUS   = 8'h0C;  // Barrier and decode state
  localparam logic [1:0] GPR_REGION   = 2'h1;   // addr[7:6] of register file window

  // Field positions
  localparam int CTRL_COND    = 0;   // Inside a conditional-execution block
  localparam int FLAG_LSB     = 28;  // N,Z,C,V occupy bits 31:28
  localparam int ST_COMPLETE  = 0;   // Completion barrier holding issue
  localparam int ST_ORDER     = 1;   // Ordering barrier holding accesses
  localparam int ST_PREFIX    = 2;   // First half of a wide op captured
  localparam int ST_UNKNOWN   = 3;   // Last halfword not recognised
  localparam int ST_OPT_LSB   = 4;   // Last barrier option, 4 bits
  localparam int ST_FULL      = 8;   // Last barrier used the full option

  // Reset values
  localparam logic [31:0] GPR_RESET  = 32'h0000_0000;
  localparam logic [15:0] HW_RESET   = 16'h0000;

  // Instruction encodings
  localparam logic [9:0]  OP_CMN_REG  = 10'h10B;
  localparam logic [9:0]  OP_CMP_REG  = 10'h10A;
  localparam logic [9:0]  OP_XOR      = 10'h101;
  localparam logic [4:0]  OP_CMP_IMM  = 5'h05;
  localparam logic [7:0]  OP_CMP_WIDE = 8'h45;
  localparam logic [15:0] BAR_PREFIX  = 16'hF3BF;
  localparam logic [11:0] BAR_ORDER   = 12'h8F5;
  localparam logic [11:0] BAR_COMPL   = 12'h8F4;
  localparam logic [3:0]  FULL_OPTION = 4'hF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } nzcv_t;

  typedef struct packed {
    logic [31:0] sum;
    logic        c;
    logic        v;
  } alu_t;

  typedef enum logic [2:0] {
    BAR_IDLE     = 3'b001,
    BAR_ORDERING = 3'b010,
    BAR_COMPLETE = 3'b100
  } bar_state_t;

  // Add with carry, producing carry-out and signed overflow
  function automatic alu_t add_with_carry(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic        cin);
    logic [32:0] wide;
    alu_t        r;
    wide  = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
    r.sum = wide[31:0];
    r.c   = wide[32];
    r.v   = (a[31] == b[31]) && (wide[31] != a[31]);
    return r;
  endfunction

endpackage

// file: compare_barrier_xor_exec.sv
// Execute block for compares, memory barriers and register xor
//
// How it works
// - Add-compare adds registers, carry zero, flags only
// - Compare flags: N bit31, Z, carry, overflow
// - Immediate compare adds inverted literal plus one
// - Immediate literal 8 bits unsigned, 3-bit register
// - Register compare adds inverted operand plus one
// - Narrow register compare uses registers 0 to 7
// - Wide compare: high bit forms 4-bit first index
// - Odd wide index combinations executed plainly
// - Stack pointer accepted as either compare operand
// - Ordering barrier: earlier accesses observed before later
// - Ordering barrier never stalls other instructions
// - Ordering barrier: all options act as full
// - Completion barrier holds issue until memory and maintenance idle
// - Completion barrier: all options act as full
// - Xor writes result back to combined register
// - Xor sets flags only outside conditional block
// - Xor flags: N, Z from result, C and V kept
`timescale 1ns/10ps
module compare_barrier_xor_exec
  import cbx_pkg::*;
(
  input  wire logic        mclk,         // 40 MHz core clock
  input  wire logic        rst_b,        // Async reset, active low
  input  wire logic        ce,           // Clock enable, freezes state when low
  input  wire logic [7:0]  awaddr,       // AXI write address
  input  wire logic        awvalid,      // AXI write address valid
  output logic             awready,      // AXI write address ready
  input  wire logic [31:0] wdata,        // AXI write data
  input  wire logic [3:0]  wstrb,        // AXI write strobes
  input  wire logic        wvalid,       // AXI write data valid
  output logic             wready,       // AXI write data ready
  output logic [1:0]       bresp,        // AXI write response
  output logic             bvalid,       // AXI write response valid
  input  wire logic        bready,       // AXI write response ready
  input  wire logic [7:0]  araddr,       // AXI read address
  input  wire logic        arvalid,      // AXI read address valid
  output logic             arready,      // AXI read address ready
  output logic [31:0]      rdata,        // AXI read data
  output logic [1:0]       rresp,        // AXI read response
  output logic             rvalid,       // AXI read valid
  input  wire logic        rready,       // AXI read ready
  input  wire logic        mem_pending,  // Explicit memory accesses outstanding
  input  wire logic        maint_busy,   // Cache or predictor maintenance running
  output logic             order_hold,   // Later explicit accesses must wait
  output logic             issue_stall   // Later instructions must wait
);

  // ************************************************************
  // State
  // ************************************************************
  logic [31:0] gpr [16];
  nzcv_t       flags;
  logic        in_cond;
  bar_state_t  bar_state;
  logic [15:0] prefix_hw;
  logic        prefix_valid;
  logic        last_unknown;
  logic [3:0]  last_option;
  logic        last_full;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic        wr_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_merged;
  logic [31:0] wr_old;
  logic        wr_hit;

  // Issue is frozen by holding off new writes during a completion barrier;
  // ready also drops with the clock enable so a frozen block loses no handshake
  assign issue_stall = (bar_state == BAR_COMPLETE);
  assign awready     = ce && !aw_held && !bvalid && !issue_stall;
  assign wready      = ce && !w_held && !bvalid && !issue_stall;

  // A write fires once both halves are in hand, taken or held
  assign wr_fire = ce && !bvalid && (aw_held || (awvalid && awready))
                   && (w_held || (wvalid && wready));
  assign wr_addr = aw_held ? aw_addr_q : awaddr;

  // Capture address and data independently; order between them is free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else begin
        if (awvalid && awready) begin
          aw_held   <= 1'b1;
          aw_addr_q <= awaddr;
        end
        if (wvalid && wready) begin
          w_held   <= 1'b1;
          w_data_q <= wdata;
          w_strb_q <= wstrb;
        end
      end
    end
  end

  // Old contents of the target, so byte strobes merge cleanly
  always_comb begin
    wr_hit = 1'b1;
    wr_old = 32'h0000_0000;
    if (wr_addr[7:6] == GPR_REGION) begin
      wr_old = gpr[wr_addr[5:2]];
    end else begin
      case (wr_addr)
        OFS_INSTR: wr_old = 32'h0000_0000;
        OFS_CTRL:  wr_old = {31'h0000_0000, in_cond};
        OFS_FLAGS: wr_old = {flags, 28'h000_0000};
        default:   wr_hit = 1'b0;
      endcase
    end
  end

  // Byte-lane merge driven by the write strobes
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wr_merged[lane*8 +: 8] = (aw_held ? w_strb_q[lane] : wstrb[lane])
                                      ? (w_held ? w_data_q[lane*8 +: 8]
                                                : wdata[lane*8 +: 8])
                                      : wr_old[lane*8 +: 8];
    end
  endgenerate

  // Write response: unmapped addresses answer with a slave error
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Decode of the issued halfword
  // ************************************************************
  logic [15:0] hw;
  logic        issue;
  logic        is_cmn;
  logic        is_cmp_imm;
  logic        is_cmp_nar;
  logic        is_cmp_wide;
  logic        is_xor;
  logic        is_prefix;
  logic        is_order;
  logic        is_compl;
  logic [3:0]  idx_a;
  logic [3:0]  idx_b;
  logic [31:0] opnd_b;
  logic        carry_in;
  alu_t        alu;
  logic [31:0] xor_res;

  assign hw    = wr_merged[15:0];
  assign issue = wr_fire && (wr_addr == OFS_INSTR);

  assign is_order    = prefix_valid && (prefix_hw == BAR_PREFIX) && (hw[15:4] == BAR_ORDER);
  assign is_compl    = prefix_valid && (prefix_hw == BAR_PREFIX) && (hw[15:4] == BAR_COMPL);
  assign is_prefix   = !prefix_valid && (hw == BAR_PREFIX);
  assign is_cmn      = !prefix_valid && (hw[15:6] == OP_CMN_REG);
  assign is_cmp_imm  = !prefix_valid && (hw[15:11] == OP_CMP_IMM);
  assign is_cmp_nar  = !prefix_valid && (hw[15:6] == OP_CMP_REG);
  assign is_cmp_wide = !prefix_valid && (hw[15:8] == OP_CMP_WIDE);
  assign is_xor      = !prefix_valid && (hw[15:6] == OP_XOR);

  // Operand selection for every compare and the xor
  always_comb begin
    idx_a    = {1'b0, hw[2:0]};
    idx_b    = {1'b0, hw[5:3]};
    carry_in = 1'b1;
    if (is_cmp_imm) begin
      idx_a = {1'b0, hw[10:8]};
    end else if (is_cmp_wide) begin
      idx_a = {hw[7], hw[2:0]};
      idx_b = hw[6:3];
    end
    if (is_cmn) begin
      carry_in = 1'b0;
    end
  end

  assign opnd_b  = is_cmn ? gpr[idx_b]
                 : is_cmp_imm ? ~{24'h00_0000, hw[7:0]}
                 : ~gpr[idx_b];
  assign alu     = add_with_carry(gpr[idx_a], opnd_b, carry_in);
  assign xor_res = gpr[idx_a] ^ gpr[idx_b];

  // ************************************************************
  // Register file: software writes and xor write-back
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= GPR_RESET;
      end
    end else if (ce && wr_fire) begin
      if (wr_addr[7:6] == GPR_REGION) begin
        gpr[wr_addr[5:2]] <= wr_merged;
      end else if (issue && is_xor) begin
        gpr[idx_a] <= xor_res;
      end
    end
  end

  // ************************************************************
  // Flag status word and conditional-block control
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags   <= '0;
      in_cond <= 1'b0;
    end else if (ce && wr_fire) begin
      if (wr_addr == OFS_FLAGS) begin
        flags <= wr_merged[31:FLAG_LSB];
      end else if (wr_addr == OFS_CTRL) begin
        in_cond <= wr_merged[CTRL_COND];
      end else if (issue && (is_cmn || is_cmp_imm || is_cmp_nar || is_cmp_wide)) begin
        flags <= '{n: alu.sum[31], z: (alu.sum == 32'h0000_0000), c: alu.c, v: alu.v};
      end else if (issue && is_xor && !in_cond) begin
        flags.n <= xor_res[31];
        flags.z <= (xor_res == 32'h0000_0000);
      end
    end
  end

  // ************************************************************
  // Decode bookkeeping: wide prefix and last-op status
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prefix_hw    <= HW_RESET;
      prefix_valid <= 1'b0;
      last_unknown <= 1'b0;
      last_option  <= 4'h0;
      last_full    <= 1'b0;
    end else if (ce && issue) begin
      prefix_valid <= is_prefix;
      prefix_hw    <= hw;
      last_unknown <= !(is_prefix || is_order || is_compl || is_cmn || is_cmp_imm
                        || is_cmp_nar || is_cmp_wide || is_xor);
      if (is_order || is_compl) begin
        last_option <= hw[3:0];
        last_full   <= (hw[3:0] == FULL_OPTION);
      end
    end
  end

  // ************************************************************
  // Barrier sequencer
  // ************************************************************
  // option ignored
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bar_state <= BAR_IDLE;
    end else if (ce) begin
      case (bar_state)
        BAR_IDLE: begin
          if (issue && is_compl) begin
            bar_state <= BAR_COMPLETE;
          end else if (issue && is_order) begin
            bar_state <= BAR_ORDERING;
          end
        end
        BAR_ORDERING: begin
          if (issue && is_compl) begin
            bar_state <= BAR_COMPLETE;
          end else if (!mem_pending && !(issue && is_order)) begin
            bar_state <= BAR_IDLE;
          end
        end
        BAR_COMPLETE: begin
          if (!mem_pending && !maint_busy) begin
            bar_state <= BAR_IDLE;
          end
        end
        default: bar_state <= BAR_IDLE;
      endcase
    end
  end

  assign order_hold = (bar_state != BAR_IDLE);

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // Address is refused while frozen, else the master would think it taken
  assign arready = ce && !rvalid;

  // Read data is registered; unmapped addresses answer with a slave error
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        rdata  <= 32'h0000_0000;
        if (araddr[7:6] == GPR_REGION) begin
          rdata <= gpr[araddr[5:2]];
        end else begin
          case (araddr)
            OFS_INSTR:  rdata <= {16'h0000, prefix_hw};
            OFS_CTRL:   rdata <= {31'h0000_0000, in_cond};
            OFS_FLAGS:  rdata <= {flags, 28'h000_0000};
            OFS_STATUS: begin
              rdata[ST_COMPLETE]             <= (bar_state == BAR_COMPLETE);
              rdata[ST_ORDER]                <= (bar_state == BAR_ORDERING);
              rdata[ST_PREFIX]               <= prefix_valid;
              rdata[ST_UNKNOWN]              <= last_unknown;
              rdata[ST_OPT_LSB +: 4]         <= last_option;
              rdata[ST_FULL]                 <= last_full;
            end
            default:    rresp <= RESP_SLVERR;
          endcase
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  AST_CMN_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_cmn) |=> flags.c == $past(alu.c) && flags.z == ($past(alu.sum) == 0))
    else $error("add-compare flags wrong");

  AST_CMP_N: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && (is_cmp_nar || is_cmp_wide)) |=> flags.n == $past(alu.sum[31]))
    else $error("compare negative flag wrong");

  AST_CMP_IMM_EQ: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_cmp_imm && gpr[hw[10:8]] == {24'h00_0000, hw[7:0]})
    |=> flags.z && flags.c)
    else $error("equal immediate compare must set Z and C");

  AST_WIDE_IDX: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_cmp_wide && gpr[{hw[7], hw[2:0]}] == gpr[hw[6:3]])
    |=> flags.z && flags.c)
    else $error("wide compare index wrong");

  AST_XOR_WB: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_xor) |=> gpr[$past(idx_a)] == $past(xor_res))
    else $error("xor result not written back");

  AST_XOR_COND: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_xor && in_cond) |=> $stable(flags))
    else $error("xor changed flags inside conditional block");

  AST_XOR_V: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_xor) |=> flags.v == $past(flags.v) && flags.c == $past(flags.c))
    else $error("xor altered V or C");

  AST_COMPL_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    (bar_state == BAR_COMPLETE && (mem_pending || maint_busy)) |=> issue_stall && !awready)
    else $error("completion barrier released early");

  AST_ORDER_FREE: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && bar_state == BAR_ORDERING && !aw_held && !bvalid) |-> awready && !issue_stall)
    else $error("ordering barrier stalled issue");

  AST_ORDER_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_order) |=> order_hold)
    else $error("ordering barrier did not hold accesses");

  AST_PREFIX: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && issue && is_prefix) |=> prefix_valid ##0 prefix_hw == BAR_PREFIX)
    else $error("barrier prefix not captured");

endmodule // compare_barrier_xor_exec

// file: mem_side_model.sv
// Memory-side model driving outstanding access and maintenance levels
`timescale 1ns/10ps
module mem_side_model (
  input  wire logic       mclk,        // Core clock
  input  wire logic       rst_b,       // Async reset, active low
  input  wire logic       start,       // Load both busy counts
  input  wire logic [7:0] pend_len,    // Cycles of outstanding accesses
  input  wire logic [7:0] maint_len,   // Cycles of maintenance work
  output logic            mem_pending, // Accesses outstanding
  output logic            maint_busy   // Maintenance running
);
  logic [7:0] pend_cnt;
  logic [7:0] maint_cnt;

  // Count both activities down; a zero length answers at once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_cnt  <= 8'h00;
      maint_cnt <= 8'h00;
    end else if (start) begin
      pend_cnt  <= pend_len;
      maint_cnt <= maint_len;
    end else begin
      pend_cnt  <= pend_cnt - 8'((pend_cnt != 8'h00));
      maint_cnt <= maint_cnt - 8'((maint_cnt != 8'h00));
    end
  end

  // Levels come from registers, so they never glitch mid-cycle
  assign mem_pending = (pend_cnt != 8'h00);
  assign maint_busy  = (maint_cnt != 8'h00);
endmodule // mem_side_model

// file: compare_barrier_xor_exec_test.sv
// Self-checking bench for the compare, barrier and xor execute block
`timescale 1ns/10ps
module compare_barrier_xor_exec_test;
  import cbx_pkg::*;
  logic        mclk, rst_b, start;
  logic [7:0]  awaddr, araddr, pend_len, maint_len;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        mem_pending, maint_busy, order_hold, issue_stall;
  int          errors, checks_done, cycles;

  compare_barrier_xor_exec i_compare_barrier_xor_exec (
    .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mem_pending(mem_pending), .maint_busy(maint_busy), .order_hold(order_hold),
    .issue_stall(issue_stall));

  mem_side_model i_mem_side_model (
    .mclk(mclk), .rst_b(rst_b), .start(start), .pend_len(pend_len),
    .maint_len(maint_len), .mem_pending(mem_pending), .maint_busy(maint_busy));

  // Free-running 40 MHz clock
  always #12.5 mclk = ~mclk;

  // Watchdog: the whole run needs well under 5000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // ********
  // Helpers
  // ********
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] gpr(input int n);
    return 8'h40 + 8'(4 * n);
  endfunction

  // Ready is read just after the edge, before the design's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        break;
      end
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        break;
      end
      if (!ar_done && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_done = 1'b1;
      end
    end
    chk($sformatf("rdata_%h", a), ed, rdata & mask);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  task automatic issue(input logic [15:0] hw);
    wr(OFS_INSTR, {16'h0000, hw}, RESP_OKAY);
  endtask

  task automatic flags_are(input logic [31:0] e);
    rd(OFS_FLAGS, 32'hFFFF_FFFF, e, RESP_OKAY);
  endtask

  task automatic start_model(input logic [7:0] p, input logic [7:0] m);
    @(posedge mclk);
    pend_len  <= p;
    maint_len <= m;
    start     <= 1'b1;
    @(posedge mclk);
    start     <= 1'b0;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    flags_are(32'h0000_0000);
    rd(gpr(1), 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    issue(BAR_PREFIX);
    rd(OFS_STATUS, 32'h0000_000C, 32'h0000_0004, RESP_OKAY);
    rd(OFS_INSTR, 32'hFFFF_FFFF, {16'h0000, BAR_PREFIX}, RESP_OKAY);
    // A non-barrier second half is unrecognised and drops the held prefix
    issue(16'h0000);
    rd(OFS_STATUS, 32'h0000_000F, 32'h0000_0008, RESP_OKAY);
  endtask

  task automatic t_compares();
    wr(gpr(0), 32'h7FFF_FFFF, RESP_OKAY);
    wr(gpr(1), 32'h0000_0001, RESP_OKAY);
    issue({OP_CMN_REG, 3'd1, 3'd0});
    flags_are(32'h9000_0000);
    rd(gpr(0), 32'hFFFF_FFFF, 32'h7FFF_FFFF, RESP_OKAY);
    wr(gpr(2), 32'h0000_0005, RESP_OKAY);
    issue({OP_CMP_IMM, 3'd2, 8'hFF});
    flags_are(32'h8000_0000);
    issue({OP_CMP_IMM, 3'd2, 8'h05});
    flags_are(32'h6000_0000);
    wr(gpr(3), 32'h8000_0000, RESP_OKAY);
    wr(gpr(4), 32'h0000_0001, RESP_OKAY);
    issue({OP_CMP_REG, 3'd4, 3'd3});
    flags_are(32'h3000_0000);
    wr(gpr(13), 32'h0000_000A, RESP_OKAY);
    wr(gpr(8), 32'h0000_000A, RESP_OKAY);
    issue({OP_CMP_WIDE, 1'b1, 4'h8, 3'd5});
    flags_are(32'h6000_0000);
    rd(gpr(13), 32'hFFFF_FFFF, 32'h0000_000A, RESP_OKAY);
  endtask

  task automatic t_xor();
    wr(OFS_FLAGS, 32'h3000_0000, RESP_OKAY);
    wr(gpr(5), 32'hF0F0_0000, RESP_OKAY);
    wr(gpr(6), 32'hF0F0_0000, RESP_OKAY);
    issue({OP_XOR, 3'd6, 3'd5});
    rd(gpr(5), 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
    flags_are(32'h7000_0000);
    // Inside a conditional block a negative result must not reach the flags
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(gpr(5), 32'h8000_0001, RESP_OKAY);
    wr(gpr(6), 32'h0000_0001, RESP_OKAY);
    issue({OP_XOR, 3'd6, 3'd5});
    rd(gpr(5), 32'hFFFF_FFFF, 32'h8000_0000, RESP_OKAY);
    flags_are(32'h7000_0000);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_order(input logic [3:0] opt);
    start_model(8'd40, 8'd0);
    issue(BAR_PREFIX);
    issue({BAR_ORDER, opt});
    chk("order_hold", 32'h1, 32'(order_hold));
    chk("issue_stall", 32'h0, 32'(issue_stall));
    wr(gpr(7), 32'hA5A5_0000, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_01F6, {23'h0, opt == FULL_OPTION, opt, 4'h2}, RESP_OKAY);
    while (mem_pending === 1'b1) @(posedge mclk);
    chk("order_hold", 32'h1, 32'(order_hold));
    repeat (2) @(posedge mclk);
    chk("order_hold", 32'h0, 32'(order_hold));
  endtask

  task automatic t_complete(input logic [3:0] opt, input logic [7:0] p, input logic [7:0] m);
    start_model(p, m);
    issue(BAR_PREFIX);
    issue({BAR_COMPL, opt});
    chk("issue_stall", 32'h1, 32'(issue_stall));
    rd(OFS_STATUS, 32'h0000_01F1, {23'h0, opt == FULL_OPTION, opt, 4'h1}, RESP_OKAY);
    chk("awready", 32'h0, 32'(awready));
    while (mem_pending === 1'b1 || maint_busy === 1'b1) @(posedge mclk);
    chk("issue_stall", 32'h1, 32'(issue_stall));
    repeat (2) @(posedge mclk);
    chk("issue_stall", 32'h0, 32'(issue_stall));
    chk("order_hold", 32'h0, 32'(order_hold));
  endtask

  // Main sequence: reset for ten cycles, then every scenario in turn
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    start = 1'b0;
    {awaddr, araddr, pend_len, maint_len, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_compares();
    t_xor();
    t_order(4'h3);
    t_order(FULL_OPTION);
    t_complete(FULL_OPTION, 8'd20, 8'd40);
    t_complete(4'h0, 8'd40, 8'd5);
    end_sim();
  end
endmodule // compare_barrier_xor_exec_test
